// ---- shared/rcs_params.svh ----
// constants of the rail configuration and current-share block
`ifndef RCS_PARAMS_SVH
`define RCS_PARAMS_SVH

// command codes
`define RCS_CMD_MISC 8'hD1
`define RCS_CMD_SHARE 8'hD2
`define RCS_CMD_GBCFG 8'hD3
`define RCS_CMD_READ_LO 8'h88
`define RCS_CMD_READ_HI 8'h9F

// reset values
`define RCS_MISC_RST 16'h0000
`define RCS_SHARE_RST 16'h0000
`define RCS_GBCFG_RST 16'h0000

// option word bit positions
`define RCS_MISC_SYNC_TMO 11
`define RCS_MISC_NO_VINCORR 9
`define RCS_MISC_FLT_IMMED 8
`define RCS_MISC_SYNC_EXT 6
`define RCS_MISC_SYNC_OUT 5
`define RCS_MISC_LOWSIDE 2
`define RCS_MISC_STBY_HI 1
`define RCS_MISC_STBY_LO 0

// membership word fields
`define RCS_SHARE_ID_HI 15
`define RCS_SHARE_ID_LO 8
`define RCS_SHARE_CNT_HI 7
`define RCS_SHARE_CNT_LO 5
`define RCS_SHARE_POS_HI 4
`define RCS_SHARE_POS_LO 2
`define RCS_SHARE_EN 0

// group bus config field
`define RCS_GB_ID_HI 4
`define RCS_GB_ID_LO 0
`define RCS_GB_MASK 16'h001F

// sync shutoff delay
`define RCS_SYNC_OFF_MS 500
`define RCS_CLK_KHZ 50000
`define RCS_SYNC_OFF_CYC (`RCS_SYNC_OFF_MS * `RCS_CLK_KHZ)

`endif

// ---- shared/rcs_pkg.sv ----
// types of the rail configuration and current-share block
package rcs_pkg;

	typedef enum logic [1:0] {
		STBY_LOW_POWER = 2'b00,
		STBY_MONITOR = 2'b01,
		STBY_RESERVED = 2'b10,
		STBY_PULSED = 2'b11
	} rcs_stby_t;

	typedef enum logic [1:0] {
		TMR_ON = 2'b00,
		TMR_COUNT = 2'b01,
		TMR_OFF = 2'b11
	} rcs_tmr_state_t;

endpackage

// ---- shared/rcs_tmr_if.sv ----
// link between the option logic and the sync shutoff timer
`timescale 1ns/1ps
interface rcs_tmr_if;
	logic disabled;
	logic timeoutEn;
	logic syncRun;

	modport ctl (
		output disabled,
		output timeoutEn,
		input syncRun
	);

	modport tmr (
		input disabled,
		input timeoutEn,
		output syncRun
	);
endinterface

// ---- rtl/rcs_sync_timer.sv ----
// sync output shutoff timer after disable
`timescale 1ns/1ps
`include "rcs_params.svh"
module rcs_sync_timer #(
	parameter int unsigned OFF_CYCLES = `RCS_SYNC_OFF_CYC
) (
	input wire logic clk,
	input wire logic reset_n,
	rcs_tmr_if.tmr tmr
);
	rcs_pkg::rcs_tmr_state_t state_reg;
	rcs_pkg::rcs_tmr_state_t state_next;
	logic [31:0] count_reg;
	logic [31:0] count_next;
	logic run_reg;
	wire logic countDone;

	assign countDone = (count_reg >= OFF_CYCLES - 32'd1);

	always_comb begin
		state_next = state_reg;
		count_next = count_reg;
		case (state_reg)
			rcs_pkg::TMR_ON: begin
				count_next = 32'd0;
				if (tmr.disabled && tmr.timeoutEn) begin
					state_next = rcs_pkg::TMR_COUNT;
				end
			end
			rcs_pkg::TMR_COUNT: begin
				count_next = count_reg + 32'd1;
				if (!tmr.disabled || !tmr.timeoutEn) begin
					state_next = rcs_pkg::TMR_ON;
				end else if (countDone) begin
					state_next = rcs_pkg::TMR_OFF;
				end
			end
			rcs_pkg::TMR_OFF: begin
				count_next = 32'd0;
				if (!tmr.disabled || !tmr.timeoutEn) begin
					state_next = rcs_pkg::TMR_ON;
				end
			end
			default: begin
				state_next = rcs_pkg::TMR_ON;
				count_next = 32'd0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= rcs_pkg::TMR_ON;
			count_reg <= 32'd0;
			run_reg <= 1'b1;
		end else begin
			state_reg <= state_next;
			count_reg <= count_next;
			run_reg <= (state_next != rcs_pkg::TMR_OFF);
		end
	end

	assign tmr.syncRun = run_reg;
endmodule

// ---- rtl/rcs_top.sv ----
// option word, current-share membership and their effect on the rail
`timescale 1ns/1ps
`include "rcs_params.svh"
module rcs_top #(
	parameter int unsigned SYNC_OFF_CYCLES = `RCS_SYNC_OFF_CYC
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic cmdValid,
	input wire logic cmdWrite,
	input wire logic [7:0] cmdCode,
	input wire logic [15:0] cmdWdata,
	output logic rspValid,
	output logic [15:0] rspData,
	output logic rspError,
	output logic rspForward,
	output logic cmlFault,
	input wire logic cmlClear,
	input wire logic deviceEnable,
	input wire logic seqEnable,
	input wire logic peerFault,
	input wire logic peerGroupHit,
	input wire logic peerFaultIsOwnRail,
	output logic shutdownNow,
	output logic seqDownReq,
	output logic seqDownFromSelf,
	input wire logic intSwClk,
	input wire logic syncPinIn,
	input wire logic syncStrapExt,
	output logic syncPinOut,
	output logic syncPinOe,
	output logic swClk,
	output logic swClkExt,
	output logic vinCorrEn,
	output logic lowSideHold,
	output logic lowPower,
	output logic monitorCont,
	output logic monitorPulsed,
	output logic [4:0] railId,
	output logic shareMember,
	output logic [3:0] memberCount,
	output logic [3:0] memberPos
);
	logic [15:0] misc_reg;
	logic [15:0] share_reg;
	logic [15:0] gbcfg_reg;
	logic syncMeta_reg;
	logic syncSync_reg;
	logic strapMeta_reg;
	logic strapSync_reg;
	logic [1:0] strapWait_reg;
	logic strapExt_reg;
	logic cml_next;

	// command decode
	wire logic hitMisc;
	wire logic hitShare;
	wire logic hitGb;
	wire logic hitRead;
	wire logic cmdWr;
	wire logic cmdRd;
	wire logic readBlocked;
	wire logic unmapped;
	wire logic [15:0] rdMux;

	assign hitMisc = (cmdCode == `RCS_CMD_MISC);
	assign hitShare = (cmdCode == `RCS_CMD_SHARE);
	assign hitGb = (cmdCode == `RCS_CMD_GBCFG);
	assign hitRead = (cmdCode >= `RCS_CMD_READ_LO) && (cmdCode <= `RCS_CMD_READ_HI);
	assign cmdWr = cmdValid && cmdWrite;
	assign cmdRd = cmdValid && !cmdWrite;
	assign unmapped = !(hitMisc || hitShare || hitGb || (hitRead && !cmdWrite));
	assign rdMux = hitMisc ? misc_reg :
		hitShare ? share_reg :
		hitGb ? (gbcfg_reg & `RCS_GB_MASK) :
		16'h0000;

	// option fields
	wire logic disabled;
	wire logic optSyncTmo;
	wire logic optNoVinCorr;
	wire logic optFltImmed;
	wire logic optSyncExt;
	wire logic optSyncOut;
	wire logic optLowSide;
	rcs_pkg::rcs_stby_t stbyMode;
	wire logic lowPowerNow;
	wire logic monContNow;
	wire logic monPulsedNow;

	assign disabled = !deviceEnable;
	assign optSyncTmo = misc_reg[`RCS_MISC_SYNC_TMO];
	assign optNoVinCorr = misc_reg[`RCS_MISC_NO_VINCORR];
	assign optFltImmed = misc_reg[`RCS_MISC_FLT_IMMED];
	assign optSyncExt = misc_reg[`RCS_MISC_SYNC_EXT];
	assign optSyncOut = misc_reg[`RCS_MISC_SYNC_OUT];
	assign optLowSide = misc_reg[`RCS_MISC_LOWSIDE];
	assign stbyMode = rcs_pkg::rcs_stby_t'(misc_reg[`RCS_MISC_STBY_HI:`RCS_MISC_STBY_LO]);
	// reserved standby code behaves as low power
	assign lowPowerNow = disabled && ((stbyMode == rcs_pkg::STBY_LOW_POWER) ||
		(stbyMode == rcs_pkg::STBY_RESERVED));
	assign monContNow = disabled && (stbyMode == rcs_pkg::STBY_MONITOR);
	assign monPulsedNow = disabled && (stbyMode == rcs_pkg::STBY_PULSED);
	assign readBlocked = cmdRd && hitRead && lowPowerNow;

	// membership fields
	wire logic shareEn;
	wire logic [4:0] shareId;
	wire logic [4:0] gbId;
	wire logic [3:0] cntNow;
	wire logic [3:0] posNow;
	wire logic [4:0] idNow;

	assign shareEn = share_reg[`RCS_SHARE_EN];
	// id range is 0-31, upper field bits are not used
	assign shareId = share_reg[`RCS_SHARE_ID_LO + 4:`RCS_SHARE_ID_LO];
	assign gbId = gbcfg_reg[`RCS_GB_ID_HI:`RCS_GB_ID_LO];
	assign idNow = shareEn ? shareId : gbId;
	assign cntNow = {1'b0, share_reg[`RCS_SHARE_CNT_HI:`RCS_SHARE_CNT_LO]} + 4'h1;
	assign posNow = {1'b0, share_reg[`RCS_SHARE_POS_HI:`RCS_SHARE_POS_LO]} + 4'h1;

	// fault spreading
	wire logic peerHit;
	wire logic immedNow;
	wire logic seqNow;

	assign peerHit = peerFault && peerGroupHit;
	assign immedNow = optFltImmed && peerHit;
	assign seqNow = !optFltImmed && peerFault && seqEnable;

	rcs_tmr_if tmrLink();

	// clock source selection
	wire logic extClkNow;
	wire logic syncDriveNow;

	assign extClkNow = optSyncExt || strapExt_reg;
	assign syncDriveNow = optSyncOut && !extClkNow && tmrLink.syncRun;

	assign tmrLink.disabled = disabled;
	assign tmrLink.timeoutEn = optSyncTmo;

	rcs_sync_timer #(
		.OFF_CYCLES(SYNC_OFF_CYCLES)
	) u_timer (
		.clk(clk),
		.reset_n(reset_n),
		.tmr(tmrLink)
	);

	// pin synchronisers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			syncMeta_reg <= 1'b0;
			syncSync_reg <= 1'b0;
			strapMeta_reg <= 1'b0;
			strapSync_reg <= 1'b0;
		end else begin
			syncMeta_reg <= syncPinIn;
			syncSync_reg <= syncMeta_reg;
			strapMeta_reg <= syncStrapExt;
			strapSync_reg <= strapMeta_reg;
		end
	end

	// strap is caught once, after the pin chain holds the pin's value instead of its reset value
	wire logic strapTake;
	wire logic strapDone;

	assign strapTake = (strapWait_reg == 2'h2);
	assign strapDone = (strapWait_reg == 2'h3);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			strapWait_reg <= 2'h0;
			strapExt_reg <= 1'b0;
		end else begin
			if (!strapDone) begin
				strapWait_reg <= strapWait_reg + 2'h1;
			end
			if (strapTake) begin
				strapExt_reg <= strapSync_reg;
			end
		end
	end

	// register writes
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			misc_reg <= `RCS_MISC_RST;
			share_reg <= `RCS_SHARE_RST;
			gbcfg_reg <= `RCS_GBCFG_RST;
		end else if (cmdWr) begin
			if (hitMisc) begin
				misc_reg <= cmdWdata;
			end
			if (hitShare) begin
				share_reg <= cmdWdata;
			end
			if (hitGb) begin
				gbcfg_reg <= cmdWdata & `RCS_GB_MASK;
			end
		end
	end

	// communication fault flag, a new event wins over clear
	assign cml_next = readBlocked ? 1'b1 : (cmlClear ? 1'b0 : cmlFault);

	// command answers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rspValid <= 1'b0;
			rspData <= 16'h0000;
			rspError <= 1'b0;
			rspForward <= 1'b0;
		end else begin
			rspValid <= cmdValid;
			rspData <= cmdRd ? rdMux : 16'h0000;
			rspError <= cmdValid && (unmapped || readBlocked);
			rspForward <= cmdRd && hitRead && !lowPowerNow;
		end
	end

	// sticky communication fault
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cmlFault <= 1'b0;
		end else begin
			cmlFault <= cml_next;
		end
	end

	// fault spreading outputs
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			shutdownNow <= 1'b0;
			seqDownReq <= 1'b0;
			seqDownFromSelf <= 1'b0;
		end else begin
			shutdownNow <= immedNow;
			seqDownReq <= seqNow;
			seqDownFromSelf <= seqNow && peerFaultIsOwnRail;
		end
	end

	// sync pin and switching clock outputs
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			syncPinOut <= 1'b0;
			syncPinOe <= 1'b0;
			swClk <= 1'b0;
			swClkExt <= 1'b0;
		end else begin
			syncPinOut <= syncDriveNow && intSwClk;
			syncPinOe <= syncDriveNow;
			swClk <= extClkNow ? syncSync_reg : intSwClk;
			swClkExt <= extClkNow;
		end
	end

	// option level outputs
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			vinCorrEn <= 1'b1;
			lowSideHold <= 1'b0;
			lowPower <= 1'b0;
			monitorCont <= 1'b0;
			monitorPulsed <= 1'b0;
		end else begin
			vinCorrEn <= !optNoVinCorr;
			lowSideHold <= disabled && optLowSide;
			lowPower <= lowPowerNow;
			monitorCont <= monContNow;
			monitorPulsed <= monPulsedNow;
		end
	end

	// membership outputs
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			railId <= 5'h00;
			shareMember <= 1'b0;
			memberCount <= 4'h1;
			memberPos <= 4'h1;
		end else begin
			railId <= idNow;
			shareMember <= shareEn;
			memberCount <= cntNow;
			memberPos <= posNow;
		end
	end
endmodule

// ---- tb/rcs_top_monitor.sv ----
// port-level checks of the option and membership block
`timescale 1ns/1ps
module rcs_top_monitor (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic cmdValid,
	input wire logic cmdWrite,
	input wire logic [7:0] cmdCode,
	input wire logic [15:0] cmdWdata,
	input wire logic rspValid,
	input wire logic rspError,
	input wire logic cmlFault,
	input wire logic deviceEnable,
	input wire logic seqEnable,
	input wire logic peerFault,
	input wire logic peerGroupHit,
	input wire logic peerFaultIsOwnRail,
	input wire logic shutdownNow,
	input wire logic seqDownReq,
	input wire logic seqDownFromSelf,
	input wire logic vinCorrEn,
	input wire logic lowSideHold,
	input wire logic lowPower,
	input wire logic [4:0] railId,
	input wire logic shareMember,
	input wire logic [3:0] memberCount,
	input wire logic [3:0] memberPos
);
	logic [15:0] optReg;
	wire optWr = cmdValid && cmdWrite && cmdCode == 8'hD1;
	wire shrWr = cmdValid && cmdWrite && cmdCode == 8'hD2;
	wire measRd = cmdValid && !cmdWrite && cmdCode >= 8'h88 && cmdCode <= 8'h9F;
	// shadow of the option word for the fault checks
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			optReg <= 16'h0000;
		end else if (optWr) begin
			optReg <= cmdWdata;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence s_opt;
		optWr;
	endsequence
	sequence s_shr;
		shrWr;
	endsequence
	sequence s_offOpt;
		(s_opt and !deviceEnable) ##1 (!deviceEnable [*2]);
	endsequence
	AST_RSP: assert property (cmdValid |=> rspValid) else $error("late reply");
	AST_SHUT: assert property (peerFault && peerGroupHit && optReg[8] |=> shutdownNow)
		else $error("no shutdown");
	AST_SEQ: assert property (peerFault && !optReg[8] && seqEnable
		|=> seqDownReq && seqDownFromSelf == $past(peerFaultIsOwnRail)) else $error("no sequence down");
	AST_VIN: assert property (s_opt |=> ##1 vinCorrEn == !$past(cmdWdata[9], 2))
		else $error("bad correction");
	AST_LOW: assert property (s_offOpt |-> lowSideHold == $past(cmdWdata[2], 2))
		else $error("bad low side");
	AST_CNT: assert property (s_shr |=> ##1 memberCount == {1'b0, $past(cmdWdata[7:5], 2)} + 4'h1
		&& memberPos == {1'b0, $past(cmdWdata[4:2], 2)} + 4'h1) else $error("bad count");
	AST_MEM: assert property (s_shr |=> ##1 shareMember == $past(cmdWdata[0], 2)
		&& (!shareMember || railId == $past(cmdWdata[12:8], 2))) else $error("bad member");
	AST_CML: assert property (measRd && lowPower |=> rspError && cmlFault)
		else $error("no fault");
endmodule

// ---- tb/rcs_host.sv ----
// host model issuing word commands
`timescale 1ns/1ps
module rcs_host (
	input wire logic clk,
	output logic cmdValid,
	output logic cmdWrite,
	output logic [7:0] cmdCode,
	output logic [15:0] cmdWdata,
	input wire logic [15:0] rspData,
	input wire logic rspError
);
	initial begin
		cmdValid = 1'b0;
		cmdWrite = 1'b0;
		cmdCode = 8'h00;
		cmdWdata = 16'h0000;
	end
	// one whole word per command, answer taken one cycle later
	task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
		output logic [15:0] q, output logic e);
		@(posedge clk);
		cmdValid <= 1'b1;
		cmdWrite <= w;
		cmdCode <= c;
		cmdWdata <= d;
		@(posedge clk);
		cmdValid <= 1'b0;
		cmdWdata <= ~d;
		#1;
		q = rspData;
		e = rspError;
	endtask
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench of the option and membership block
`timescale 1ns/1ps
module tb_top;
	logic clk, reset_n, cmdValid, cmdWrite, rspValid, rspError, rspForward, cmlFault, cmlClear;
	logic deviceEnable, seqEnable, peerFault, peerGroupHit, peerFaultIsOwnRail, shutdownNow;
	logic seqDownReq, seqDownFromSelf, intSwClk, syncPinOut, syncPinOe, swClk, swClkExt;
	logic vinCorrEn, lowSideHold, lowPower, monitorCont, monitorPulsed, shareMember, e, syncPinIn;
	logic [7:0] cmdCode;
	logic [15:0] cmdWdata, rspData, q;
	logic [4:0] railId;
	logic [3:0] memberCount, memberPos;
	logic [2:0] sb [4] = '{3'b100, 3'b010, 3'b100, 3'b001};
	int failures = 0;
	int comparisons = 0;
	rcs_top #(.SYNC_OFF_CYCLES(20)) rcs_top_inst (.clk, .reset_n, .cmdValid, .cmdWrite, .cmdCode, .cmdWdata,
		.rspValid, .rspData, .rspError, .rspForward, .cmlFault, .cmlClear, .deviceEnable, .seqEnable,
		.peerFault, .peerGroupHit, .peerFaultIsOwnRail, .shutdownNow, .seqDownReq, .seqDownFromSelf,
		.intSwClk, .syncPinIn, .syncStrapExt(1'b0), .syncPinOut, .syncPinOe, .swClk, .swClkExt,
		.vinCorrEn, .lowSideHold, .lowPower, .monitorCont, .monitorPulsed, .railId, .shareMember,
		.memberCount, .memberPos);
	rcs_host rcs_host_inst (.clk, .cmdValid, .cmdWrite, .cmdCode, .cmdWdata, .rspData, .rspError);
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) intSwClk <= ~intSwClk;
	task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
		comparisons++;
		if (g !== x) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		rcs_host_inst.xfer(1'b1, c, d, q, e);
		@(posedge clk);
		#1;
	endtask
	task automatic rd(input logic [7:0] c, input logic [15:0] x, input logic xe);
		rcs_host_inst.xfer(1'b0, c, 16'h0000, q, e);
		chk("rspData", x, q);
		chk("rspError", {15'h0000, xe}, {15'h0000, e});
	endtask
	task automatic t_regs();
		wr(8'hD1, 16'hA35A);
		rd(8'hD1, 16'hA35A, 1'b0);
		chk("vinCorrEn", 16'h0000, {15'h0000, vinCorrEn});
		wr(8'hD1, 16'h0000);
		chk("vinCorrEn", 16'h0001, {15'h0000, vinCorrEn});
		wr(8'hD3, 16'hFFE5);
		rd(8'hD3, 16'h0005, 1'b0);
		rd(8'h00, 16'h0000, 1'b1);
		rcs_host_inst.xfer(1'b1, 8'h8B, 16'h1234, q, e);
		chk("measWrite", 16'h0001, {15'h0000, e});
	endtask
	task automatic t_share();
		for (int i = 0; i < 8; i++) begin
			wr(8'hD2, {((i % 2 == 1) ? 8'h05 : 8'h09), 3'(i), 3'(7 - i), 1'b0, 1'(i)});
			chk("memberCount", 16'(i + 1), {12'h000, memberCount});
			chk("memberPos", 16'(8 - i), {12'h000, memberPos});
			chk("member", 16'(i % 2), {15'h0000, shareMember});
			chk("railId", 16'h0005, {11'h000, railId});
		end
		rd(8'hD2, 16'h05E1, 1'b0);
	endtask
	task automatic fcase(input logic [15:0] m, input logic s, input logic g, input logic o, input logic [2:0] x);
		wr(8'hD1, m);
		@(posedge clk);
		seqEnable <= s;
		peerFault <= 1'b1;
		peerGroupHit <= g;
		peerFaultIsOwnRail <= o;
		@(posedge clk);
		peerFault <= 1'b0;
		#1;
		chk("faultResp", {13'h0000, x}, {13'h0000, shutdownNow, seqDownReq, seqDownFromSelf});
	endtask
	task automatic t_fault();
		fcase(16'h0100, 1'b0, 1'b1, 1'b0, 3'b100);
		fcase(16'h0100, 1'b1, 1'b0, 1'b1, 3'b000);
		fcase(16'h0000, 1'b1, 1'b0, 1'b1, 3'b011);
		fcase(16'h0000, 1'b0, 1'b1, 1'b1, 3'b000);
	endtask
	task automatic t_standby();
		@(posedge clk);
		deviceEnable <= 1'b0;
		for (int s = 0; s < 4; s++) begin
			wr(8'hD1, 16'h0004 | 16'(s));
			chk("standby", {13'h0000, sb[s]}, {13'h0000, lowPower, monitorCont, monitorPulsed});
			chk("lowSide", 16'h0001, {15'h0000, lowSideHold});
			rd(8'h8B, 16'h0000, s % 2 == 0);
			chk("cmlFault", 16'(s % 2 == 0), {15'h0000, cmlFault});
			chk("rspForward", 16'(s % 2), {15'h0000, rspForward});
			@(posedge clk);
			cmlClear <= 1'b1;
			@(posedge clk);
			cmlClear <= 1'b0;
		end
	endtask
	task automatic t_sync();
		@(posedge clk);
		deviceEnable <= 1'b1;
		wr(8'hD1, 16'h0820);
		chk("syncOe", 16'h0001, {15'h0000, syncPinOe});
		chk("syncOut", {15'h0000, ~intSwClk}, {15'h0000, syncPinOut});
		chk("swClk", {15'h0000, ~intSwClk}, {15'h0000, swClk});
		@(posedge clk);
		deviceEnable <= 1'b0;
		repeat (17) @(posedge clk);
		#1;
		chk("syncOe", 16'h0001, {15'h0000, syncPinOe});
		repeat (8) @(posedge clk);
		#1;
		chk("syncOe", 16'h0000, {15'h0000, syncPinOe});
		wr(8'hD1, 16'h0020);
		repeat (30) @(posedge clk);
		#1;
		chk("syncOe", 16'h0001, {15'h0000, syncPinOe});
		wr(8'hD1, 16'h0060);
		chk("extClk", 16'h0003, {14'h0000, swClkExt, ~syncPinOe});
		@(posedge clk);
		syncPinIn <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk("swClk", 16'h0001, {15'h0000, swClk});
		@(posedge clk);
		syncPinIn <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk("swClk", 16'h0000, {15'h0000, swClk});
	endtask
	task automatic end_of_test();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		{reset_n, cmlClear, seqEnable, peerFault, peerGroupHit, peerFaultIsOwnRail, intSwClk, syncPinIn} = '0;
		deviceEnable = 1'b1;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		t_regs();
		t_share();
		t_fault();
		t_standby();
		t_sync();
		end_of_test();
	end
endmodule
bind rcs_top rcs_top_monitor rcs_top_monitor_inst (.clk, .reset_n, .cmdValid, .cmdWrite, .cmdCode, .cmdWdata,
	.rspValid, .rspError, .cmlFault, .deviceEnable, .seqEnable, .peerFault, .peerGroupHit, .peerFaultIsOwnRail,
	.shutdownNow, .seqDownReq, .seqDownFromSelf, .vinCorrEn, .lowSideHold, .lowPower, .railId, .shareMember,
	.memberCount, .memberPos);
